// File: rtl/bit_toggle_pkg.sv
// shared constants and carrier types of the bit-toggle execution core
package bit_toggle_pkg;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int BANK_W = 4;
  localparam logic [3:0] OP_TOGGLE = 4'h7;
  localparam logic [7:0] OP_BRANCH_OV = 8'he4;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int BIT_HI = 11;
  localparam int BIT_LO = 9;
  localparam int ACC_POS = 8;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } phase_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic digitCarry;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic valid;
    logic isToggle;
    logic isBranch;
    logic [2:0] bitSel;
    logic [7:0] literal;
  } decoded_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } mem_write_t;
endpackage : bit_toggle_pkg

// File: rtl/data_mem.sv
// byte-wide data memory, registered read port and one write port
`timescale 1ns/1ps
module data_mem
  import bit_toggle_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // clock
  input wire logic clk,
  // read port
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData,
  // write port
  input wire mem_write_t wr
);
  // the write carrier has a fixed address width, so the read side must match it
  if (AW != ADDR_W)
  begin : gen_bad_aw
    $error("memory address width must match the write carrier");
  end

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    rdData <= mem[rdAddr];
  end

  always_ff @(posedge clk)
  begin
    if (wr.en)
    begin
      mem[wr.addr] <= wr.data;
    end
  end
endmodule : data_mem

// File: rtl/bit_toggle_exec.sv
// bit-toggle and branch-on-overflow execution over four quarter phases
`timescale 1ns/1ps
module bit_toggle_exec
  import bit_toggle_pkg::*;
#(
  parameter int BW = BANK_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction stream
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  // addressing context
  input wire logic extEnable,
  input wire logic [BW-1:0] bankSelect,
  input wire logic [ADDR_W-1:0] indexBase,
  // status flags, loaded by other instructions only
  input wire logic statusLoad,
  input wire flags_t statusNext,
  output flags_t status,
  // program counter
  output logic [PC_W-1:0] pc,
  // outside write access to data memory
  input wire mem_write_t extWrite,
  output logic extWriteReady,
  // byte written by a toggle, shown only in the cycle after the write
  output mem_write_t lastWrite,
  output phase_t phase
);
  // the banked address is bank bits over the file byte, so widths must add up
  if (BW + 8 != ADDR_W)
  begin : gen_bad_width
    $error("bank width plus file width must equal address width");
  end

  decoded_t dec;
  decoded_t next_dec;
  logic [ADDR_W-1:0] effAddr;
  logic [ADDR_W-1:0] next_effAddr;
  logic [7:0] rdData;
  logic [7:0] modByte;
  logic flush;
  logic taken;
  logic toggleWrite;
  mem_write_t wr;
  logic [7:0] fileAddr;
  logic [PC_W-1:0] branchOffset;

  assign fileAddr = instrWord[ACC_POS-1:0];
  assign instrReady = (phase == Q1) && !flush;
  assign taken = dec.valid && dec.isBranch && status.ovf;
  assign toggleWrite = (phase == Q4) && dec.valid && dec.isToggle;
  assign extWriteReady = !toggleWrite;
  // sign-extend and double the literal, -128..127 words
  assign branchOffset = {{(PC_W-9){dec.literal[7]}}, dec.literal, 1'b0};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= Q1;
    end
    else
    begin
      case (phase)
        Q1: phase <= Q2;
        Q2: phase <= Q3;
        Q3: phase <= Q4;
        Q4: phase <= Q1;
        default: phase <= Q1;
      endcase
    end
  end

  always_comb
  begin
    next_dec = '0;
    next_dec.valid = instrValid;
    next_dec.isToggle = instrWord[OPC_HI:OPC_LO] == OP_TOGGLE;
    next_dec.isBranch = instrWord[OPC_HI:ACC_POS] == OP_BRANCH_OV;
    next_dec.bitSel = instrWord[BIT_HI:BIT_LO];
    next_dec.literal = fileAddr;
  end

  always_comb
  begin
    next_effAddr = {bankSelect, fileAddr};
    if (!instrWord[ACC_POS])
    begin
      if (extEnable && fileAddr <= INDEXED_MAX)
      begin
        next_effAddr = ADDR_W'(indexBase + {{(ADDR_W-8){1'b0}}, fileAddr});
      end
      else if (fileAddr < ACCESS_SPLIT)
      begin
        next_effAddr = {ACCESS_LOW_BANK, fileAddr};
      end
      else
      begin
        next_effAddr = {ACCESS_HIGH_BANK, fileAddr};
      end
    end
  end

  // decode happens in the first quarter only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec <= '0;
      effAddr <= '0;
    end
    else if (phase == Q1)
    begin
      dec <= instrReady ? next_dec : decoded_t'(0);
      effAddr <= next_effAddr;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modByte <= '0;
    end
    else if (phase == Q3)
    begin
      modByte <= rdData ^ (8'h01 << dec.bitSel);
    end
  end

  // a taken branch discards the already fetched word: second cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= PC_RESET;
      flush <= 1'b0;
    end
    else if (phase == Q4)
    begin
      flush <= taken;
      if (taken)
      begin
        pc <= PC_W'(pc + PC_STEP + branchOffset);
      end
      else if (dec.valid)
      begin
        pc <= PC_W'(pc + PC_STEP);
      end
    end
  end

  // no toggle path touches the flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= '0;
    end
    else if (statusLoad)
    begin
      status <= statusNext;
    end
  end

  always_comb
  begin
    wr = extWrite;
    if (toggleWrite)
    begin
      wr.en = 1'b1;
      wr.addr = effAddr;
      wr.data = modByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastWrite <= '0;
    end
    else
    begin
      lastWrite <= toggleWrite ? wr : mem_write_t'(0);
    end
  end

  // read address is held from Q1 so data lands in Q3
  data_mem #(
    .AW(ADDR_W)
  ) data_mem_inst (
    .clk(clk),
    .rdAddr(effAddr),
    .rdData(rdData),
    .wr(wr)
  );

  phase_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == Q1 |=> phase == Q2 ##1 phase == Q3 ##1 phase == Q4 ##1 phase == Q1)
    else $error("quarter phases out of order");

  toggle_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    instrReady && instrValid && instrWord[15:12] == 4'h7 |=> dec.isToggle && dec.valid)
    else $error("toggle opcode not recognised");

  toggle_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    toggleWrite |-> wr.addr == effAddr && $onehot(wr.data ^ $past(rdData))
      && (wr.data ^ $past(rdData)) == (8'h01 << dec.bitSel))
    else $error("toggle did not invert exactly the selected bit");

  status_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
    dec.isToggle && !$past(statusLoad) |-> $stable(status))
    else $error("status changed during toggle");

  bank_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    instrReady && instrWord[8] |=> effAddr == {$past(bankSelect), $past(instrWord[7:0])})
    else $error("banked address wrong");

  access_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
    instrReady && !instrWord[8] && !(extEnable && instrWord[7:0] <= 8'h5f)
    |=> effAddr[7:0] == $past(instrWord[7:0])
      && effAddr[11:8] == ($past(instrWord[7]) || $past(instrWord[6:5]) == 2'b11 ? 4'hf : 4'h0))
    else $error("access bank address wrong");

  indexed_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    instrReady && !instrWord[8] && extEnable && instrWord[7:0] <= 8'h5f
    |=> effAddr == 12'($past(indexBase) + $past(instrWord[7:0])))
    else $error("indexed literal offset address wrong");

  branch_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == Q4 && taken |=> pc == 21'($past(pc) + 21'h2
      + {{12{$past(dec.literal[7])}}, $past(dec.literal), 1'b0}) && !instrReady)
    else $error("taken branch target or second cycle wrong");

  branch_not_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == Q4 && dec.valid && !taken |=> pc == 21'($past(pc) + 21'h2) && instrReady)
    else $error("untaken branch should take one cycle");
endmodule : bit_toggle_exec

// File: sim/bit_toggle_exec_tb_top.sv
// self-checking bench for the bit-toggle execution core
`timescale 1ns/1ps
module bit_toggle_exec_tb_top;
  import bit_toggle_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic instrReady;
  logic extEnable = 1'b0;
  logic [BANK_W-1:0] bankSelect = 4'h0;
  logic [ADDR_W-1:0] indexBase = 12'h000;
  logic statusLoad = 1'b0;
  flags_t statusNext = 5'h00;
  flags_t status;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] expPc = PC_RESET;
  mem_write_t extWrite = '0;
  logic extWriteReady;
  mem_write_t lastWrite;
  phase_t phase;
  int badCount = 0;
  int nCompared = 0;

  bit_toggle_exec bit_toggle_exec_inst (
    .clk(clk),
    .rst_n(rst_n),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .instrReady(instrReady),
    .extEnable(extEnable),
    .bankSelect(bankSelect),
    .indexBase(indexBase),
    .statusLoad(statusLoad),
    .statusNext(statusNext),
    .status(status),
    .pc(pc),
    .extWrite(extWrite),
    .extWriteReady(extWriteReady),
    .lastWrite(lastWrite),
    .phase(phase)
  );

  initial
  begin
    forever #4 clk = ~clk;
  end

  task ck(input logic ok, input string msg);
    nCompared++;
    if (ok !== 1'b1)
    begin
      badCount++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : ck

  task end_of_test;
    $display("compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // memory is not reset, so every target byte is preloaded first
  task poke(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    extWrite <= {1'b1, a, d};
    @(posedge clk);
    extWrite <= '0;
  endtask : poke

  // wait for a settled Q4, then drive at its closing edge so the next Q1 edge takes
  task issue(input logic [15:0] w);
    do
    begin
      @(posedge clk);
      #1;
    end
    while (phase !== Q4);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clk);
    instrValid <= 1'b0;
  endtask : issue

  task tog(input logic [2:0] b, input logic a, input logic [7:0] f,
           input logic [11:0] ea, input logic [7:0] d);
    flags_t s;
    s = status;
    poke(ea, d);
    issue({OP_TOGGLE, b, a, f});
    repeat (2) @(posedge clk);
    #1 ck(extWriteReady === 1'b0, "outside write not held off in Q4");
    ck(lastWrite.en === 1'b0, "write seen before the Q4 edge");
    @(posedge clk);
    #1 ck(pc === expPc + PC_STEP, "pc step");
    ck(lastWrite === {1'b1, ea, d ^ (8'h01 << b)}, "toggled byte or address");
    ck(status === s, "flags changed by toggle");
    expPc = expPc + PC_STEP;
    @(posedge clk);
    #1 ck(lastWrite.en === 1'b0, "write pulse longer than one cycle");
  endtask : tog

  // all flags follow ovf so a later toggle sees a full flag set
  task br(input logic ovf, input logic [7:0] n);
    logic [PC_W-1:0] nxt;
    @(posedge clk);
    statusLoad <= 1'b1;
    statusNext <= {5{ovf}};
    @(posedge clk);
    statusLoad <= 1'b0;
    nxt = expPc + PC_STEP + (ovf ? {{12{n[7]}}, n, 1'b0} : 21'h000000);
    issue({OP_BRANCH_OV, n});
    repeat (3) @(posedge clk);
    #1 ck(pc === nxt, "branch target");
    ck(instrReady === !ovf, "dead cycle after branch");
    expPc = nxt;
  endtask : br

  // an unknown opcode still advances pc but writes no byte
  task nop_word;
    issue(16'h0000);
    repeat (3) @(posedge clk);
    #1 ck(pc === expPc + PC_STEP && lastWrite.en === 1'b0, "unknown opcode");
    expPc = expPc + PC_STEP;
  endtask : nop_word

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1 ck(pc === PC_RESET && phase === Q1 && status === 5'h00, "reset state");
    tog(3'd4, 1'b0, 8'h25, 12'h025, 8'h75);
    tog(3'd7, 1'b0, 8'h60, 12'hf60, 8'h00);
    tog(3'd0, 1'b0, 8'hff, 12'hfff, 8'h5a);
    @(posedge clk);
    bankSelect <= 4'h3;
    tog(3'd1, 1'b1, 8'h60, 12'h360, 8'hff);
    @(posedge clk);
    extEnable <= 1'b1;
    indexBase <= 12'h200;
    tog(3'd2, 1'b0, 8'h5f, 12'h25f, 8'h00);
    tog(3'd3, 1'b0, 8'h60, 12'hf60, 8'hff);
    tog(3'd5, 1'b1, 8'h10, 12'h310, 8'h20);
    br(1'b1, 8'h80);
    tog(3'd6, 1'b0, 8'h00, 12'h200, 8'hc3);
    br(1'b1, 8'h7f);
    br(1'b0, 8'h7f);
    nop_word;
    tog(3'd6, 1'b0, 8'h00, 12'h200, 8'h83);
    end_of_test;
  end

  initial
  begin
    #20000;
    badCount++;
    end_of_test;
  end
endmodule : bit_toggle_exec_tb_top
